//--- hw/tic_regs.svh
// register offsets, field positions, reset values and codes of the timer channel block
// assumes a 32-bit apb slave, one aligned word per register
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH
`define TIC_OFF_MAIN 8'h00
`define TIC_OFF_CNT 8'h04
`define TIC_OFF_MOD 8'h08
`define TIC_OFF_CH0_CS 8'h0c
`define TIC_OFF_CH0_VAL 8'h10
`define TIC_OFF_CH1_CS 8'h14
`define TIC_OFF_CH1_VAL 8'h18
`define TIC_OFF_BRK 8'h1c
`define TIC_MAIN_PS_LSB 0
`define TIC_MAIN_STOP_BIT 4
`define TIC_MAIN_RST_BIT 5
`define TIC_BRK_BCE_BIT 0
`define TIC_CS_FLAG_BIT 7
`define TIC_PS_EXT 3'h7
`define TIC_MAIN_RESET 8'h00
`define TIC_MOD_RESET 16'hffff
`define TIC_CS_RESET 8'h00
`endif

//--- hw/tic_pkg.sv
// types shared by the timer channel block
// assumes tic_regs.svh for all numeric codes
package tic_pkg;
   typedef enum logic [1:0] {
      TIC_ELS_OFF,
      TIC_ELS_A,
      TIC_ELS_B,
      TIC_ELS_AB
   } tic_els_t;
   // layout matches the channel control/status byte, msb first
   typedef struct packed {
      logic flag;
      logic irq_en;
      logic buf_sel;
      logic oc_mode;
      tic_els_t els;
      logic tov;
      logic chmax;
   } tic_chcfg_t;
   typedef struct packed {
      logic rise;
      logic fall;
      logic lvl;
   } tic_pin_t;
endpackage : tic_pkg

//--- hw/tic_pin_sync.sv
// synchroniser and edge detector for the timer pins
// assumes pins are slow against pclk
`timescale 1ns/1ps
module tic_pin_sync import tic_pkg::*; #(
   parameter int W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] pin,
   output tic_pin_t ev [W]
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   for (genvar i = 0; i < W; i++) begin : g_ev
      assign ev[i].rise = s2_r[i] & ~s3_r[i];
      assign ev[i].fall = ~s2_r[i] & s3_r[i];
      assign ev[i].lvl = s2_r[i];
   end
endmodule : tic_pin_sync

//--- hw/tic_channel.sv
// one capture/compare channel: value register, edge match, compare match, pin level
// assumes cnt_upd pulses in the cycle after the counter moved
`timescale 1ns/1ps
module tic_channel import tic_pkg::*; #(
   parameter int CNT_W = 16,
   parameter bit BUF_EN = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input tic_chcfg_t cfg,
   input wire logic [CNT_W-1:0] cnt,
   input wire logic cnt_upd,
   input wire logic ovf,
   input tic_pin_t pin,
   input wire logic val_we,
   input wire logic [CNT_W-1:0] val_wdata,
   output logic [CNT_W-1:0] val,
   output logic pin_lvl,
   output logic event_hit
);
   logic [CNT_W-1:0] val_r;
   logic [CNT_W-1:0] shadow_r;
   logic shadow_pend_r;
   logic pin_r;
   logic cap_hit;
   logic cmp_hit;
   logic buf_on;
   assign buf_on = BUF_EN & cfg.buf_sel;
   always_comb begin
      cap_hit = 1'b0;
      if (!cfg.oc_mode) begin
         case (cfg.els)
            TIC_ELS_A: cap_hit = pin.rise;
            TIC_ELS_B: cap_hit = pin.fall;
            TIC_ELS_AB: cap_hit = pin.rise | pin.fall;
            default: cap_hit = 1'b0;
         endcase
      end
   end
   assign cmp_hit = cfg.oc_mode & cnt_upd & (cnt == val_r);
   assign event_hit = cap_hit | cmp_hit;
   assign val = val_r;
   assign pin_lvl = pin_r;
   // a buffered write lands at overflow so a pwm period never sees a half-updated value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         val_r <= '0;
         shadow_r <= '0;
         shadow_pend_r <= 1'b0;
      end else if (cap_hit) begin
         val_r <= cnt;
      end else if (val_we && buf_on) begin
         shadow_r <= val_wdata;
         shadow_pend_r <= 1'b1;
      end else if (val_we) begin
         val_r <= val_wdata;
      end else if (ovf && shadow_pend_r) begin
         val_r <= shadow_r;
         shadow_pend_r <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_r <= 1'b0;
      end else if (cfg.chmax) begin
         pin_r <= (cfg.els == TIC_ELS_AB);
      end else if (cmp_hit) begin
         case (cfg.els)
            TIC_ELS_A: pin_r <= ~pin_r;
            TIC_ELS_B: pin_r <= 1'b0;
            TIC_ELS_AB: pin_r <= 1'b1;
            default: pin_r <= pin_r;
         endcase
      end else if (ovf && cfg.tov) begin
         pin_r <= ~pin_r;
      end
   end
   cap_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_hit |=> val_r == $past(cnt)) else $error("capture did not latch counter");
   duty_force_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.chmax |=> pin_r == ($past(cfg.els) == TIC_ELS_AB)) else $error("forced duty level wrong");
endmodule : tic_channel

//--- hw/tic_top.sv
// timer capture/compare block: apb registers, prescaler, counter, two channels, pin muxing
// assumes break_active and wait_mode come from the system integration unit, synchronous to pclk
// Contract
// - timer runs in wait; register access refused there; enabled request wakes processor.
// - counter holds while break is active.
// - break_clear_enable set: flags may be cleared in break, staying cleared.
// - break_clear_enable clear: accesses in break never alter status flags.
// - first clear step before break survives it; second step afterwards clears.
// - prescaler select all ones picks external clock pin as counter source.
// - external clock pin is input while selected, whatever port direction says.
// - three port a lines shared: two channel pins and external clock.
// - channels independently capture or compare; only channel 0 buffers.
// - capture trigger: rising, falling or either edge.
// - compare match drives high, low or toggles output.
// - output may toggle on overflow; duty forced to 0% or 100%.
// - capture edge sets channel event flag.
// - counter equal to compare value sets channel event flag.
// - flag cleared by read with flag set, then writing 0.
// - new event between read and write makes clearing write ignored.
// - reset clears flag; writing 1 to flag does nothing.
// - interrupt enable lets flag raise request; reset clears it.
// - buffered mode select exists only in channel 0 register.
`timescale 1ns/1ps
`include "tic_regs.svh"
module tic_top import tic_pkg::*; #(
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic break_active,
   input wire logic wait_mode,
   input wire logic [2:0] port_dir,
   input wire logic [2:0] port_data,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   output logic [1:0] ch_irq,
   output logic wake_req
);
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [2:0] ps_r;
   logic stop_r;
   logic bce_r;
   logic [CNT_W-1:0] mod_r;
   logic [CNT_W-1:0] cnt_r;
   logic cnt_upd_r;
   logic ovf_r;
   logic [6:0] div_r;
   logic [6:0] div_mask;
   logic tick;
   logic run;
   logic [1:0] flag_r;
   logic [1:0] arm_r;
   logic [1:0] ch_irq_r;
   logic wake_r;
   logic [2:0] pin_out_r;
   logic [2:0] pin_oe_r;
   tic_chcfg_t cfg_r [2];
   tic_chcfg_t cfg_v [2];
   tic_pin_t pin_ev [3];
   logic [CNT_W-1:0] ch_val [2];
   logic [1:0] ch_ev;
   logic [1:0] ch_lvl;
   logic acc;
   logic wr;
   logic rd;
   logic unmapped;
   logic brk_ok;
   logic [31:0] rd_mux;
   logic [1:0] cs_sel;
   logic [1:0] val_sel;
   logic [1:0] clr_go;
   logic [1:0] arm_go;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ch_irq = ch_irq_r;
   assign wake_req = wake_r;
   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;

   // one wait state so read data and error come from flops
   assign acc = psel & penable & pready_r;
   assign wr = acc & pwrite & ~pslverr_r;
   assign rd = acc & ~pwrite & ~pslverr_r;
   assign brk_ok = ~break_active | bce_r;
   assign cs_sel[0] = (paddr == `TIC_OFF_CH0_CS);
   assign cs_sel[1] = (paddr == `TIC_OFF_CH1_CS);
   assign val_sel[0] = (paddr == `TIC_OFF_CH0_VAL);
   assign val_sel[1] = (paddr == `TIC_OFF_CH1_VAL);

   always_comb begin
      unmapped = 1'b0;
      rd_mux = '0;
      if (paddr == `TIC_OFF_MAIN) begin
         rd_mux[`TIC_MAIN_PS_LSB +: 3] = ps_r;
         rd_mux[`TIC_MAIN_STOP_BIT] = stop_r;
      end else if (paddr == `TIC_OFF_CNT) begin
         rd_mux[CNT_W-1:0] = cnt_r;
      end else if (paddr == `TIC_OFF_MOD) begin
         rd_mux[CNT_W-1:0] = mod_r;
      end else if (cs_sel[0]) begin
         rd_mux[7:0] = cfg_v[0];
      end else if (cs_sel[1]) begin
         rd_mux[7:0] = cfg_v[1];
      end else if (val_sel[0]) begin
         rd_mux[CNT_W-1:0] = ch_val[0];
      end else if (val_sel[1]) begin
         rd_mux[CNT_W-1:0] = ch_val[1];
      end else if (paddr == `TIC_OFF_BRK) begin
         rd_mux[`TIC_BRK_BCE_BIT] = bce_r;
      end else begin
         unmapped = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else if (psel && penable && !pready_r) begin
         pready_r <= 1'b1;
         pslverr_r <= unmapped | wait_mode;
         prdata_r <= (unmapped || wait_mode || pwrite) ? 32'h0000_0000 : rd_mux;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_r <= 3'(`TIC_MAIN_RESET);
         stop_r <= 1'b0;
         bce_r <= 1'b0;
         mod_r <= `TIC_MOD_RESET;
      end else if (wr && paddr == `TIC_OFF_MAIN) begin
         ps_r <= pwdata[`TIC_MAIN_PS_LSB +: 3];
         stop_r <= pwdata[`TIC_MAIN_STOP_BIT];
      end else if (wr && paddr == `TIC_OFF_MOD) begin
         mod_r <= pwdata[CNT_W-1:0];
      end else if (wr && paddr == `TIC_OFF_BRK) begin
         bce_r <= pwdata[`TIC_BRK_BCE_BIT];
      end
   end

   // prescaler: internal tick every 2**ps pclk cycles, or an external clock edge
   always_comb begin
      div_mask = 7'((8'h01 << ps_r) - 8'h01);
      if (ps_r == `TIC_PS_EXT) begin
         tick = pin_ev[2].rise;
      end else begin
         tick = (div_r & div_mask) == div_mask;
      end
   end
   assign run = tick & ~stop_r & ~break_active;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 7'h01;
      end
   end

   // wait mode does not gate the counter, only the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         cnt_upd_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         cnt_upd_r <= run;
         ovf_r <= run & (cnt_r == mod_r);
         if (wr && paddr == `TIC_OFF_MAIN && pwdata[`TIC_MAIN_RST_BIT]) begin
            cnt_r <= '0;
         end else if (run && cnt_r == mod_r) begin
            cnt_r <= '0;
         end else if (run) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   tic_pin_sync #(.W(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(pin_in),
      .ev(pin_ev)
   );

   for (genvar i = 0; i < 2; i++) begin : g_ch
      always_comb begin
         cfg_v[i] = cfg_r[i];
         cfg_v[i].flag = flag_r[i];
      end
      assign clr_go[i] = wr & cs_sel[i] & ~pwdata[`TIC_CS_FLAG_BIT] & arm_r[i] & brk_ok;
      assign arm_go[i] = rd & cs_sel[i] & flag_r[i] & brk_ok;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg_r[i] <= `TIC_CS_RESET;
         end else if (wr && cs_sel[i]) begin
            cfg_r[i] <= pwdata[7:0];
            cfg_r[i].flag <= 1'b0;
            if (i != 0) begin
               cfg_r[i].buf_sel <= 1'b0;
            end
         end
      end

      // set beats clear in the same cycle; a set also disarms a pending clear
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            flag_r[i] <= 1'b0;
            arm_r[i] <= 1'b0;
         end else if (ch_ev[i]) begin
            flag_r[i] <= 1'b1;
            arm_r[i] <= 1'b0;
         end else if (clr_go[i]) begin
            flag_r[i] <= 1'b0;
            arm_r[i] <= 1'b0;
         end else if (arm_go[i]) begin
            arm_r[i] <= 1'b1;
         end
      end

      tic_channel #(.CNT_W(CNT_W), .BUF_EN(i == 0)) u_ch (
         .pclk(pclk),
         .presetn(presetn),
         .cfg(cfg_r[i]),
         .cnt(cnt_r),
         .cnt_upd(cnt_upd_r),
         .ovf(ovf_r),
         .pin(pin_ev[i]),
         .val_we(wr & val_sel[i]),
         .val_wdata(pwdata[CNT_W-1:0]),
         .val(ch_val[i]),
         .pin_lvl(ch_lvl[i]),
         .event_hit(ch_ev[i])
      );

      // a channel owns its line only while its edge/level field is non-zero or chmax is set
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_out_r[i] <= 1'b0;
            pin_oe_r[i] <= 1'b0;
         end else if (cfg_r[i].els != TIC_ELS_OFF || cfg_r[i].chmax) begin
            pin_out_r[i] <= ch_lvl[i];
            pin_oe_r[i] <= cfg_r[i].oc_mode;
         end else begin
            pin_out_r[i] <= port_data[i];
            pin_oe_r[i] <= port_dir[i];
         end
      end

      sequence s_clear_write;
         clr_go[i] && !ch_ev[i];
      endsequence
      sequence s_arm_then_event;
         arm_go[i] ##1 ch_ev[i];
      endsequence

      flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
         ch_ev[i] |=> flag_r[i] && !arm_r[i]) else $error("event did not set flag");
      clear_two_a: assert property (@(posedge pclk) disable iff (!presetn)
         s_clear_write |=> !flag_r[i]) else $error("clear sequence did not clear flag");
      event_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
         s_arm_then_event |=> flag_r[i] && !arm_r[i]) else $error("new event lost to clear");
      write_one_a: assert property (@(posedge pclk) disable iff (!presetn)
         (flag_r[i] == 1'b0 && !ch_ev[i]) |=> !flag_r[i]) else $error("flag set without event");
      brk_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
         (break_active && !bce_r && !ch_ev[i]) |=> $stable(flag_r[i]) && $stable(arm_r[i]))
         else $error("status changed in break");
      brk_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
         (break_active && bce_r && wr && cs_sel[i] && !pwdata[7] && arm_r[i] && !ch_ev[i])
         |=> !flag_r[i]) else $error("break clear refused");
      irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
         ##1 ch_irq_r[i] == $past(flag_r[i] & cfg_r[i].irq_en)) else $error("irq mismatch");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_r[2] <= 1'b0;
         pin_oe_r[2] <= 1'b0;
      end else begin
         pin_out_r[2] <= port_data[2];
         pin_oe_r[2] <= port_dir[2] & (ps_r != `TIC_PS_EXT);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_irq_r <= '0;
         wake_r <= 1'b0;
      end else begin
         ch_irq_r[0] <= flag_r[0] & cfg_r[0].irq_en;
         ch_irq_r[1] <= flag_r[1] & cfg_r[1].irq_en;
         wake_r <= wait_mode & |(flag_r & {cfg_r[1].irq_en, cfg_r[0].irq_en});
      end
   end

   cnt_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (break_active && !wr) |=> $stable(cnt_r)) else $error("counter moved in break");
   ext_input_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ps_r == `TIC_PS_EXT) |=> !pin_oe_r[2]) else $error("external clock pin driven");
   wait_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready_r && wait_mode) |=> pready_r && pslverr_r) else $error("wait access not refused");
   apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> !pready_r) else $error("ready in setup");
   // ready must drop again, or a master would see a second transfer finish
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready_r |=> !pready_r) else $error("ready held over two cycles");
   err_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr_r |-> prdata_r == 32'h0000_0000) else $error("data shown on refused access");
   refuse_nowrite_a: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && pslverr_r) |=> $stable(mod_r) && $stable(bce_r) && $stable(ps_r)) else $error("refused write landed");
   wake_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wait_mode && |(flag_r & {cfg_r[1].irq_en, cfg_r[0].irq_en})) |=> wake_r) else $error("request did not wake");
   // external source: without a synchronised rising edge the count must not move
   ext_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ps_r == `TIC_PS_EXT && !pin_ev[2].rise && !wr) |=> $stable(cnt_r)) else $error("count moved without edge");
   port_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ps_r != `TIC_PS_EXT) |=> pin_oe_r[2] == $past(port_dir[2])) else $error("port direction not followed");
   // wrap and overflow pulse must agree, else buffered loads and toggles drift
   cnt_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (run && cnt_r == mod_r && !wr) |=> cnt_r == '0) else $error("counter did not wrap at modulo");
   ovf_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_r |-> cnt_r == '0) else $error("overflow without wrap");
endmodule : tic_top

//--- tb/tic_pin_model.sv
// pad-side model of the three shared timer lines
// assumes the bench sets ext_lvl just after pclk edges
`timescale 1ns/1ps
module tic_pin_model (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] ext_lvl,
   output logic [2:0] pin_in
);
   // design driver wins while enabled, outside source otherwise
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
      end
   end
endmodule : tic_pin_model

//--- tb/tic_top_tb_top.sv
// self-checking bench for the timer capture/compare block over apb
// assumes the hand-over timing: one wait state, registered pin and irq outputs
`timescale 1ns/1ps
`include "tic_regs.svh"
module tic_top_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic break_active, wait_mode, wake_req;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, c1;
   logic [2:0] port_dir, port_data, pin_in, pin_out, pin_oe, ext_lvl;
   logic [1:0] ch_irq;
   int err_count, cmp_count;
   logic [7:0] ocfg [3] = '{8'h5c, 8'h58, 8'h54};
   logic oexp [3] = '{1'b1, 1'b0, 1'b1};

   tic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .break_active(break_active), .wait_mode(wait_mode), .port_dir(port_dir), .port_data(port_data),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ch_irq(ch_irq), .wake_req(wake_req));
   tic_pin_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rq = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t no bus answer", $time);
         end_of_test();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dq;
      logic e;
      apb(1'b1, a, d, dq, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] rq);
      logic e;
      apb(1'b0, a, 32'h0, rq, e);
   endtask : rd

   // read arms the clear only while the flag is set, then write 0 to the flag
   task automatic clr(input logic [7:0] a);
      logic [31:0] t;
      rd(a, t);
      wr(a, {24'h0, 1'b0, t[6:0]});
   endtask : clr

   task automatic pin(input int i, input logic v);
      @(posedge pclk);
      ext_lvl[i] <= v;
      repeat (8) @(posedge pclk);
   endtask : pin

   task automatic wait_flag(input logic [7:0] a);
      logic [31:0] t;
      int n;
      n = 0;
      do begin
         rd(a, t);
         n++;
      end while (t[7] !== 1'b1 && n < 100);
      if (t[7] !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t flag never set", $time);
         end_of_test();
      end
   endtask : wait_flag

   initial begin
      logic e;
      {psel, penable, pwrite, break_active, wait_mode} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {port_dir, port_data, ext_lvl} = '0;
      err_count = 0;
      cmp_count = 0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TIC_OFF_CH0_CS, q); chk(q, 32'h0);
      rd(`TIC_OFF_CH1_CS, q); chk(q, 32'h0);
      rd(`TIC_OFF_BRK, q); chk(q, 32'h0);
      rd(`TIC_OFF_MOD, q); chk(q, 32'h0000ffff);
      apb(1'b0, 8'h20, 32'h0, q, e); chk(e, 1'b1);
      wr(`TIC_OFF_CH0_CS, 32'ha0);
      rd(`TIC_OFF_CH0_CS, q); chk(q, 32'h20);
      wr(`TIC_OFF_CH1_CS, 32'h20);
      rd(`TIC_OFF_CH1_CS, q); chk(q, 32'h0);
      wr(`TIC_OFF_MOD, 32'h3f);
      // every capture edge select against a rise then a fall
      for (int s = 1; s < 4; s++) begin
         wr(`TIC_OFF_CH0_CS, 32'h40 | (s << 2));
         pin(0, 1'b1);
         rd(`TIC_OFF_CH0_CS, q); chk(q[7], s[0]);
         chk(ch_irq[0], s[0]);
         clr(`TIC_OFF_CH0_CS);
         rd(`TIC_OFF_CH0_CS, q); chk(q[7], 1'b0);
         pin(0, 1'b0);
         rd(`TIC_OFF_CH0_CS, q); chk(q[7], s[1]);
         clr(`TIC_OFF_CH0_CS);
         repeat (2) @(posedge pclk);
         chk(ch_irq[0], 1'b0);
      end
      pin(0, 1'b1);
      rd(`TIC_OFF_CH0_CS, q);
      pin(0, 1'b0);
      wr(`TIC_OFF_CH0_CS, 32'h4c);
      rd(`TIC_OFF_CH0_CS, q); chk(q[7], 1'b1);
      // first clear step before break, second after it
      rd(`TIC_OFF_CH0_CS, q);
      @(posedge pclk);
      break_active <= 1'b1;
      rd(`TIC_OFF_CNT, c1);
      repeat (10) @(posedge pclk);
      rd(`TIC_OFF_CNT, q); chk(q, c1);
      wr(`TIC_OFF_CH0_CS, 32'h4c);
      rd(`TIC_OFF_CH0_CS, q); chk(q[7], 1'b1);
      @(posedge pclk);
      break_active <= 1'b0;
      wr(`TIC_OFF_CH0_CS, 32'h4c);
      rd(`TIC_OFF_CH0_CS, q); chk(q[7], 1'b0);
      wr(`TIC_OFF_BRK, 32'h1);
      pin(0, 1'b1);
      break_active <= 1'b1;
      clr(`TIC_OFF_CH0_CS);
      rd(`TIC_OFF_CH0_CS, q); chk(q[7], 1'b0);
      @(posedge pclk);
      break_active <= 1'b0;
      rd(`TIC_OFF_CH0_CS, q); chk(q[7], 1'b0);
      wr(`TIC_OFF_BRK, 32'h0);
      // ch1 compares while ch0 stays a capture channel
      wr(`TIC_OFF_CH1_VAL, 32'h20);
      for (int m = 0; m < 3; m++) begin
         wr(`TIC_OFF_CH1_CS, ocfg[m]);
         clr(`TIC_OFF_CH1_CS);
         wait_flag(`TIC_OFF_CH1_CS);
         chk({pin_oe[1], pin_out[1]}, {1'b1, oexp[m]});
         chk(ch_irq[1], 1'b1);
      end
      wr(`TIC_OFF_CH1_CS, 32'h1d);
      repeat (4) @(posedge pclk);
      chk(pin_out[1], 1'b1);
      wr(`TIC_OFF_CH1_CS, 32'h19);
      repeat (4) @(posedge pclk);
      chk(pin_out[1], 1'b0);
      // low on match, overflow 32 ticks later toggles it back high
      wr(`TIC_OFF_CH1_CS, 32'h5a);
      clr(`TIC_OFF_CH1_CS);
      wait_flag(`TIC_OFF_CH1_CS);
      repeat (40) @(posedge pclk);
      chk(pin_out[1], 1'b1);
      @(posedge pclk);
      wait_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(wake_req, 1'b1);
      apb(1'b0, `TIC_OFF_CH1_CS, 32'h0, q, e); chk(e, 1'b1);
      wait_mode <= 1'b0;
      // external clock source and port fallback on idle lines
      wr(`TIC_OFF_MOD, 32'hffff);
      wr(`TIC_OFF_CH0_CS, 32'h0);
      wr(`TIC_OFF_MAIN, 32'h27);
      port_dir <= 3'b101;
      port_data <= 3'b101;
      repeat (4) @(posedge pclk);
      chk({pin_oe[2], pin_out[2]}, 2'b01);
      chk({pin_oe[0], pin_out[0]}, 2'b11);
      rd(`TIC_OFF_CNT, c1);
      for (int k = 0; k < 5; k++) begin
         pin(2, 1'b1);
         pin(2, 1'b0);
      end
      rd(`TIC_OFF_CNT, q); chk(q, c1 + 32'h5);
      // buffered ch0 compare value waits for the next overflow
      wr(`TIC_OFF_CH0_CS, 32'h10);
      wr(`TIC_OFF_CH0_VAL, 32'h11);
      rd(`TIC_OFF_CH0_VAL, q); chk(q, 32'h11);
      wr(`TIC_OFF_CH0_CS, 32'h30);
      wr(`TIC_OFF_CH0_VAL, 32'h22);
      rd(`TIC_OFF_CH0_VAL, q); chk(q, 32'h11);
      wr(`TIC_OFF_MOD, 32'h0);
      wr(`TIC_OFF_MAIN, 32'h27);
      pin(2, 1'b1);
      rd(`TIC_OFF_CH0_VAL, q); chk(q, 32'h22);
      end_of_test();
   end
endmodule : tic_top_tb_top
